// ===== clock_and_module_stop_consts.svh
// Register map, field positions and reset values of the clock control block
`ifndef CLOCK_AND_MODULE_STOP_CONSTS_SVH
`define CLOCK_AND_MODULE_STOP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define CLK_RATIO_SELECT_ADDR   24'hFFFDC4
`define HALT_CTRL_A_ADDR        24'hFFFDC8
`define HALT_CTRL_C_ADDR        24'hFFFDCC
`define HALT_CTRL_B_ADDR        24'hFFFDD0

// ----------------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------------
`define CLK_RATIO_SELECT_MASK   16'h0777
`define HALT_CTRL_A_MASK        16'hB01B
`define HALT_CTRL_B_MASK        16'h9800
`define HALT_CTRL_C_MASK        16'h0702
`define CLK_RATIO_SELECT_RST    16'h0000
`define HALT_CTRL_A_RST         16'h301B
`define HALT_CTRL_B_RST         16'h9800
`define HALT_CTRL_C_RST         16'h0702

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SYS_CLK_SEL_LSB         8
`define PERIPH_CLK_SEL_LSB      4
`define EXTBUS_CLK_SEL_LSB      0
`define ALL_CLOCK_HALT_ENABLE   15
`define HALT_DMA_ENGINE         13
`define HALT_TRANSFER_CTRL      12
`define HALT_CONVERTER_UNIT1    4
`define HALT_CONVERTER_UNIT0    3
`define HALT_TIMER_UPPER        1
`define HALT_TIMER_LOWER        0
`define HALT_PATTERN_GENERATOR  15
`define HALT_SERIAL_UNIT4       12
`define HALT_SERIAL_UNIT3       11
`define HALT_SYNC_SERIAL2       10
`define HALT_SYNC_SERIAL1       9
`define HALT_SYNC_SERIAL0       8
`define HALT_ONCHIP_RAM         1

// ----------------------------------------------------------------------
// Ratio codes and module enable indices
// ----------------------------------------------------------------------
`define RATIO_X8                3'h0
`define RATIO_X4                3'h1
`define RATIO_X2                3'h2
`define RATIO_X1                3'h3
`define NUM_MODULES             13
`define MOD_DMA                 0
`define MOD_XFER                1
`define MOD_CONV1               2
`define MOD_CONV0               3
`define MOD_TIMER_HI            4
`define MOD_TIMER_LO            5
`define MOD_PATTERN             6
`define MOD_SERIAL4             7
`define MOD_SERIAL3             8
`define MOD_SYNC2               9
`define MOD_SYNC1               10
`define MOD_SYNC0               11
`define MOD_RAM                 12
`define SYS_DOMAIN_MASK         13'h1003

`endif

// ===== clock_and_module_stop_pkg.sv
// Types shared by the clock control block
package clock_and_module_stop_pkg;

    typedef enum logic {PWR_RUN, PWR_ALL_HALT} power_state_t;
    typedef logic [2:0]  ratio_code_t;
    typedef logic [15:0] reg_word_t;

endpackage

// ===== clk_ratio_divider.sv
// Divider that turns a ratio code into a clock enable tick
`timescale 1ns/100ps
module clk_ratio_divider
    import clock_and_module_stop_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Ratio code in, enable tick out
    input  wire ratio_code_t code,
    output logic             tick
);

`include "clock_and_module_stop_consts.svh"

    logic [2:0] cnt;
    logic [2:0] lim;

    // Reserved codes fall back to the slowest ratio
    always_comb
    begin
        unique case (code)
            `RATIO_X8: lim = 3'h0;
            `RATIO_X4: lim = 3'h1;
            `RATIO_X2: lim = 3'h3;
            default:   lim = 3'h7;
        endcase
    end

    // A faster code mid-count ends the current period early
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt  <= 3'h0;
            tick <= 1'b0;
        end
        else if (cnt >= lim)
        begin
            cnt  <= 3'h0;
            tick <= 1'b1;
        end
        else
        begin
            cnt  <= cnt + 3'h1;
            tick <= 1'b0;
        end
    end

endmodule

// ===== clock_and_module_stop.sv
// Clock ratio select and module stop control
//
// Summary of operation
// - System clock ratio from bits 10:8; code 000 gives eight times input.
// - Peripheral clock ratio from bits 6:4; code 001 gives four times input.
// - External bus clock ratio from bits 2:0; code 001 gives four times.
// - Stop bit one stops its module; zero lets it run again.
// - Enable bit 15 plus all stopped plus sleep enters full clock halt.
// - Full clock halt also stops bus controller and I/O ports.
// - Register A: 13 DMA, 12 transfer, 4/3 converters, 1/0 timers.
// - Register B: 15 pattern generator, 12 and 11 serial units 4, 3.
// - Register C: bits 10, 9, 8 stop sync serial units 2, 1, 0.
// - Register C bit 1 stops the on-chip RAM block.
`timescale 1ns/100ps
`include "clock_and_module_stop_consts.svh"
module clock_and_module_stop
    import clock_and_module_stop_pkg::*;
#(
    parameter int NUM_MOD = `NUM_MODULES
)
(
    // Clock and reset
    input  wire logic               CLK,
    input  wire logic               RST_N,
    // Register port
    input  wire logic [23:0]        REG_ADDR,
    input  wire logic [15:0]        REG_WDATA,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    output logic      [15:0]        REG_RDATA,
    // Processor power requests
    input  wire logic               SLEEP_REQ,
    input  wire logic               WAKE_REQ,
    // Clock enables
    output logic                    SYS_CLK_EN,
    output logic                    PERIPH_CLK_EN,
    output logic                    EXTBUS_CLK_EN,
    output logic      [NUM_MOD-1:0] MOD_CLK_EN,
    // Full clock halt status
    output logic                    ALL_STOP,
    output logic                    BUS_CTRL_HALT,
    output logic                    IO_PORT_HALT
);

    reg_word_t    clock_ratio_select;
    reg_word_t    module_halt_ctrl_a;
    reg_word_t    module_halt_ctrl_b;
    reg_word_t    module_halt_ctrl_c;
    power_state_t state;
    power_state_t next_state;
    ratio_code_t  sys_code;
    ratio_code_t  periph_code;
    ratio_code_t  extbus_code;
    logic         sys_tick;
    logic         periph_tick;
    logic         extbus_tick;
    logic         all_clock_halt_enable;
    logic         all_halted;
    logic         all_halt;
    logic [NUM_MOD-1:0] halt_vec;
    logic [NUM_MOD-1:0] sys_domain;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            clock_ratio_select <= `CLK_RATIO_SELECT_RST;
        else if (REG_WR && REG_ADDR == `CLK_RATIO_SELECT_ADDR)
            clock_ratio_select <= REG_WDATA & `CLK_RATIO_SELECT_MASK;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            module_halt_ctrl_a <= `HALT_CTRL_A_RST;
        else if (REG_WR && REG_ADDR == `HALT_CTRL_A_ADDR)
            module_halt_ctrl_a <= REG_WDATA & `HALT_CTRL_A_MASK;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            module_halt_ctrl_b <= `HALT_CTRL_B_RST;
        else if (REG_WR && REG_ADDR == `HALT_CTRL_B_ADDR)
            module_halt_ctrl_b <= REG_WDATA & `HALT_CTRL_B_MASK;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            module_halt_ctrl_c <= `HALT_CTRL_C_RST;
        else if (REG_WR && REG_ADDR == `HALT_CTRL_C_ADDR)
            module_halt_ctrl_c <= REG_WDATA & `HALT_CTRL_C_MASK;
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------

    // Data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            REG_RDATA <= 16'h0000;
        else if (REG_RD)
        begin
            unique case (REG_ADDR)
                `CLK_RATIO_SELECT_ADDR: REG_RDATA <= clock_ratio_select;
                `HALT_CTRL_A_ADDR:      REG_RDATA <= module_halt_ctrl_a;
                `HALT_CTRL_B_ADDR:      REG_RDATA <= module_halt_ctrl_b;
                `HALT_CTRL_C_ADDR:      REG_RDATA <= module_halt_ctrl_c;
                default:                REG_RDATA <= 16'h0000;
            endcase
        end
        else
            REG_RDATA <= 16'h0000;
    end

    // ------------------------------------------------------------------
    // Clock ratio dividers
    // ------------------------------------------------------------------

    assign sys_code    = clock_ratio_select[`SYS_CLK_SEL_LSB +: 3];
    assign periph_code = clock_ratio_select[`PERIPH_CLK_SEL_LSB +: 3];
    assign extbus_code = clock_ratio_select[`EXTBUS_CLK_SEL_LSB +: 3];

    clk_ratio_divider sys_div
    (
        .clk   (CLK),
        .rst_n (RST_N),
        .code  (sys_code),
        .tick  (sys_tick)
    );

    clk_ratio_divider periph_div
    (
        .clk   (CLK),
        .rst_n (RST_N),
        .code  (periph_code),
        .tick  (periph_tick)
    );

    clk_ratio_divider extbus_div
    (
        .clk   (CLK),
        .rst_n (RST_N),
        .code  (extbus_code),
        .tick  (extbus_tick)
    );

    // The processor keeps its clock in full halt so an interrupt can wake it
    assign SYS_CLK_EN    = sys_tick;
    // external bus stops in full halt
    assign PERIPH_CLK_EN = periph_tick && !all_halt;
    assign EXTBUS_CLK_EN = extbus_tick && !all_halt;

    // ------------------------------------------------------------------
    // Stop bit map
    // ------------------------------------------------------------------

    assign halt_vec[`MOD_DMA]      = module_halt_ctrl_a[`HALT_DMA_ENGINE];
    assign halt_vec[`MOD_XFER]     = module_halt_ctrl_a[`HALT_TRANSFER_CTRL];
    assign halt_vec[`MOD_CONV1]    = module_halt_ctrl_a[`HALT_CONVERTER_UNIT1];
    assign halt_vec[`MOD_CONV0]    = module_halt_ctrl_a[`HALT_CONVERTER_UNIT0];
    assign halt_vec[`MOD_TIMER_HI] = module_halt_ctrl_a[`HALT_TIMER_UPPER];
    assign halt_vec[`MOD_TIMER_LO] = module_halt_ctrl_a[`HALT_TIMER_LOWER];
    assign halt_vec[`MOD_PATTERN]  = module_halt_ctrl_b[`HALT_PATTERN_GENERATOR];
    assign halt_vec[`MOD_SERIAL4]  = module_halt_ctrl_b[`HALT_SERIAL_UNIT4];
    assign halt_vec[`MOD_SERIAL3]  = module_halt_ctrl_b[`HALT_SERIAL_UNIT3];
    assign halt_vec[`MOD_SYNC2]    = module_halt_ctrl_c[`HALT_SYNC_SERIAL2];
    assign halt_vec[`MOD_SYNC1]    = module_halt_ctrl_c[`HALT_SYNC_SERIAL1];
    assign halt_vec[`MOD_SYNC0]    = module_halt_ctrl_c[`HALT_SYNC_SERIAL0];
    assign halt_vec[`MOD_RAM]      = module_halt_ctrl_c[`HALT_ONCHIP_RAM];

    assign sys_domain = NUM_MOD'(`SYS_DOMAIN_MASK);

    // ------------------------------------------------------------------
    // Per-module clock gating
    // ------------------------------------------------------------------

    // Registered so each gated enable is glitch free; it lags its tick
    // by one cycle, which every module sees alike
    genvar i;
    generate
        for (i = 0; i < NUM_MOD; i++)
        begin : gate
            // stop bit gates the module clock
            always_ff @(posedge CLK or negedge RST_N)
            begin
                if (!RST_N)
                    MOD_CLK_EN[i] <= 1'b0;
                else
                    MOD_CLK_EN[i] <= (sys_domain[i] ? sys_tick : periph_tick)
                                     && !halt_vec[i] && !all_halt;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Full clock halt
    // ------------------------------------------------------------------

    assign all_clock_halt_enable =
        module_halt_ctrl_a[`ALL_CLOCK_HALT_ENABLE];
    assign all_halted = &halt_vec;

    // entry needs enable, all stopped and sleep
    always_comb
    begin
        next_state = state;
        unique case (state)
            PWR_RUN:
                if (SLEEP_REQ && all_clock_halt_enable && all_halted)
                    next_state = PWR_ALL_HALT;
            PWR_ALL_HALT:
                if (WAKE_REQ)
                    next_state = PWR_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            state <= PWR_RUN;
        else
            state <= next_state;
    end

    assign all_halt = (state == PWR_ALL_HALT);

    assign ALL_STOP      = all_halt;
    assign BUS_CTRL_HALT = all_halt;
    assign IO_PORT_HALT  = all_halt;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    sys_ratio_x8_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (sys_code == `RATIO_X8 && $past(sys_code) == `RATIO_X8)
            |=> SYS_CLK_EN)
        else $error("system clock not every cycle at code 000");

    periph_ratio_x4_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        // A ratio write at the tick changes the period under test
        (periph_tick && periph_code == `RATIO_X4
            && $past(periph_code) == `RATIO_X4
            && !(REG_WR && REG_ADDR == `CLK_RATIO_SELECT_ADDR))
            |=> !periph_tick ##1 periph_tick)
        else $error("peripheral clock not half rate at code 001");

    extbus_ratio_x4_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (extbus_tick && extbus_code == `RATIO_X4
            && $past(extbus_code) == `RATIO_X4
            && !(REG_WR && REG_ADDR == `CLK_RATIO_SELECT_ADDR))
            |=> !extbus_tick ##1 extbus_tick)
        else $error("external bus clock not half rate at code 001");

    halt_a_write_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == `HALT_CTRL_A_ADDR)
            |=> module_halt_ctrl_a == ($past(REG_WDATA)
                                       & `HALT_CTRL_A_MASK))
        else $error("stop register A did not take the write");

    halt_entry_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!ALL_STOP && SLEEP_REQ && all_clock_halt_enable && all_halted)
            |=> ALL_STOP && BUS_CTRL_HALT)
        else $error("full halt not entered on sleep");

    halt_blocked_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!ALL_STOP && !all_clock_halt_enable) |=> !ALL_STOP)
        else $error("full halt entered while disabled");

    halt_ports_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        ALL_STOP |-> IO_PORT_HALT && BUS_CTRL_HALT && !EXTBUS_CLK_EN
                     && !PERIPH_CLK_EN ##1 (MOD_CLK_EN == '0))
        else $error("bus or ports running in full halt");

    dma_gate_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        module_halt_ctrl_a[`HALT_DMA_ENGINE]
            |=> !MOD_CLK_EN[`MOD_DMA])
        else $error("stopped DMA engine still clocked");

    serial4_gate_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == `HALT_CTRL_B_ADDR
            && REG_WDATA[`HALT_SERIAL_UNIT4])
            |=> ##1 !MOD_CLK_EN[`MOD_SERIAL4])
        else $error("stopped serial unit 4 still clocked");

    sync2_gate_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == `HALT_CTRL_C_ADDR
            && REG_WDATA[`HALT_SYNC_SERIAL2])
            |=> ##1 !MOD_CLK_EN[`MOD_SYNC2])
        else $error("stopped sync serial unit 2 still clocked");

    ram_gate_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (REG_WR && REG_ADDR == `HALT_CTRL_C_ADDR
            && REG_WDATA[`HALT_ONCHIP_RAM])
            |=> ##1 !MOD_CLK_EN[`MOD_RAM])
        else $error("stopped on-chip RAM still clocked");

    timer_runs_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!halt_vec[`MOD_TIMER_LO] && periph_tick && !ALL_STOP)
            |=> MOD_CLK_EN[`MOD_TIMER_LO])
        else $error("running timer missed its clock");

    halt_exit_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (ALL_STOP && WAKE_REQ) |=> !ALL_STOP && !BUS_CTRL_HALT)
        else $error("full halt not left on wake");

    halt_running_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!ALL_STOP && !all_halted) |=> !ALL_STOP)
        else $error("full halt entered with a module running");

    xfer_gate_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        module_halt_ctrl_a[`HALT_TRANSFER_CTRL]
            |=> !MOD_CLK_EN[`MOD_XFER])
        else $error("stopped transfer controller still clocked");

    pattern_gate_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        module_halt_ctrl_b[`HALT_PATTERN_GENERATOR]
            |=> !MOD_CLK_EN[`MOD_PATTERN])
        else $error("stopped pattern generator still clocked");

    ram_runs_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!halt_vec[`MOD_RAM] && sys_tick && !ALL_STOP)
            |=> MOD_CLK_EN[`MOD_RAM])
        else $error("running on-chip RAM missed its clock");

endmodule

// ===== clock_and_module_stop_tb.sv
// Self-checking testbench for the clock ratio and module stop block
`timescale 1ns/100ps
`include "clock_and_module_stop_consts.svh"
module clock_and_module_stop_tb;
    import clock_and_module_stop_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        CLK;
    logic        RST_N;
    logic [23:0] REG_ADDR;
    logic [15:0] REG_WDATA;
    logic        REG_WR;
    logic        REG_RD;
    logic [15:0] REG_RDATA;
    logic        SLEEP_REQ;
    logic        WAKE_REQ;
    logic        SYS_CLK_EN;
    logic        PERIPH_CLK_EN;
    logic        EXTBUS_CLK_EN;
    logic [12:0] MOD_CLK_EN;
    logic        ALL_STOP;
    logic        BUS_CTRL_HALT;
    logic        IO_PORT_HALT;
    int          failures;
    int          check_count;
    int          n_sys;
    int          n_per;
    int          n_ext;
    int          n_mod [13];
    localparam int MOD_BIT [13] = '{13, 12, 4, 3, 1, 0, 15, 12, 11,
                                    10, 9, 8, 1};

    clock_and_module_stop clock_and_module_stop_inst (
        .CLK           (CLK),
        .RST_N         (RST_N),
        .REG_ADDR      (REG_ADDR),
        .REG_WDATA     (REG_WDATA),
        .REG_WR        (REG_WR),
        .REG_RD        (REG_RD),
        .REG_RDATA     (REG_RDATA),
        .SLEEP_REQ     (SLEEP_REQ),
        .WAKE_REQ      (WAKE_REQ),
        .SYS_CLK_EN    (SYS_CLK_EN),
        .PERIPH_CLK_EN (PERIPH_CLK_EN),
        .EXTBUS_CLK_EN (EXTBUS_CLK_EN),
        .MOD_CLK_EN    (MOD_CLK_EN),
        .ALL_STOP      (ALL_STOP),
        .BUS_CTRL_HALT (BUS_CTRL_HALT),
        .IO_PORT_HALT  (IO_PORT_HALT)
    );

    always #2.5 CLK = ~CLK;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK);
        REG_WR    <= 1'b0;
    endtask

    // Read data only stand in the cycle after the strobe
    task automatic rd(input logic [23:0] a, input logic [15:0] exp);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLK);
        REG_RD   <= 1'b0;
        #1;
        chk(REG_RDATA, exp);
    endtask

    // Raises the sleep request, or the wake request, for one cycle
    task automatic pulse(input logic wake);
        @(posedge CLK);
        if (wake)
            WAKE_REQ  <= 1'b1;
        else
            SLEEP_REQ <= 1'b1;
        @(posedge CLK);
        WAKE_REQ  <= 1'b0;
        SLEEP_REQ <= 1'b0;
        #1;
    endtask

    // Counts enable ticks over sixteen cycles
    task automatic count16();
        n_sys = 0;
        n_per = 0;
        n_ext = 0;
        for (int j = 0; j < 13; j++) n_mod[j] = 0;
        repeat (16)
        begin
            @(posedge CLK);
            #1;
            if (SYS_CLK_EN === 1'b1) n_sys++;
            if (PERIPH_CLK_EN === 1'b1) n_per++;
            if (EXTBUS_CLK_EN === 1'b1) n_ext++;
            for (int j = 0; j < 13; j++)
                if (MOD_CLK_EN[j] === 1'b1) n_mod[j]++;
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_and_masks();
        rd(`CLK_RATIO_SELECT_ADDR, `CLK_RATIO_SELECT_RST);
        rd(`HALT_CTRL_A_ADDR, `HALT_CTRL_A_RST);
        rd(`HALT_CTRL_B_ADDR, `HALT_CTRL_B_RST);
        rd(`HALT_CTRL_C_ADDR, `HALT_CTRL_C_RST);
        wr(24'hFFFDC0, 16'hFFFF);
        rd(24'hFFFDC0, 16'h0000);
        wr(`HALT_CTRL_A_ADDR, 16'hFFFF);
        rd(`HALT_CTRL_A_ADDR, 16'hB01B);
        wr(`HALT_CTRL_B_ADDR, 16'hFFFF);
        rd(`HALT_CTRL_B_ADDR, 16'h9800);
        wr(`HALT_CTRL_C_ADDR, 16'hFFFF);
        rd(`HALT_CTRL_C_ADDR, 16'h0702);
        wr(`CLK_RATIO_SELECT_ADDR, 16'hFFFF);
        rd(`CLK_RATIO_SELECT_ADDR, 16'h0777);
        wr(`HALT_CTRL_A_ADDR, `HALT_CTRL_A_RST);
    endtask

    // Every code on all three ratio fields
    task automatic test_ratios();
        logic [15:0] w;
        int          exp;
        for (int c = 0; c < 8; c++)
        begin
            w   = {5'h00, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]};
            exp = 16 >> ((c > 3) ? 3 : c);
            wr(`CLK_RATIO_SELECT_ADDR, w);
            rd(`CLK_RATIO_SELECT_ADDR, w);
            repeat (8) @(posedge CLK);
            count16();
            chk(16'(n_sys), 16'(exp));
            chk(16'(n_per), 16'(exp));
            chk(16'(n_ext), 16'(exp));
        end
    endtask

    // Release one module at a time; only it may run
    task automatic test_module_stop();
        logic [23:0] a;
        logic [15:0] rv;
        int          exp;
        wr(`CLK_RATIO_SELECT_ADDR, 16'h0011);
        for (int i = 0; i < 13; i++)
        begin
            a  = (i < 6) ? `HALT_CTRL_A_ADDR :
                 (i < 9) ? `HALT_CTRL_B_ADDR : `HALT_CTRL_C_ADDR;
            rv = (i < 6) ? `HALT_CTRL_A_RST :
                 (i < 9) ? `HALT_CTRL_B_RST : `HALT_CTRL_C_RST;
            wr(a, rv & ~(16'h0001 << MOD_BIT[i]));
            repeat (4) @(posedge CLK);
            count16();
            for (int j = 0; j < 13; j++)
            begin
                exp = (j != i) ? 0 : ((i < 2 || i == 12) ? 16 : 8);
                chk(16'(n_mod[j]), 16'(exp));
            end
            wr(a, rv);
            repeat (4) @(posedge CLK);
            count16();
            chk(16'(n_mod[i]), 16'h0000);
        end
    endtask

    task automatic test_full_halt();
        pulse(1'b0);
        chk({15'h0, ALL_STOP}, 16'h0000);
        // one module still running: sleep is ignored
        wr(`HALT_CTRL_A_ADDR, 16'hB01A);
        pulse(1'b0);
        chk({15'h0, ALL_STOP}, 16'h0000);
        wr(`HALT_CTRL_A_ADDR, 16'hB01B);
        pulse(1'b0);
        chk({13'h0, ALL_STOP, BUS_CTRL_HALT, IO_PORT_HALT}, 16'h0007);
        count16();
        chk(16'(n_per + n_ext), 16'h0000);
        chk(16'(n_sys), 16'h0010);
        chk({15'h0, ALL_STOP}, 16'h0001);
        pulse(1'b1);
        chk({13'h0, ALL_STOP, BUS_CTRL_HALT, IO_PORT_HALT}, 16'h0000);
        count16();
        chk(16'(n_per), 16'h0008);
        wr(`HALT_CTRL_A_ADDR, `HALT_CTRL_A_RST);
    endtask

    // ------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        CLK         = 1'b0;
        RST_N       = 1'b0;
        REG_ADDR    = 24'h000000;
        REG_WDATA   = 16'h0000;
        REG_WR      = 1'b0;
        REG_RD      = 1'b0;
        SLEEP_REQ   = 1'b0;
        WAKE_REQ    = 1'b0;
        failures    = 0;
        check_count = 0;
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        test_reset_and_masks();
        test_ratios();
        test_module_stop();
        test_full_halt();
        final_report();
    end

endmodule
